// [hw/xfer_seq_pkg.sv]
// shared constants and types for the memory-synchronous transfer sequencer
package xfer_seq_pkg;
  localparam int ADDR_W = 10;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] REGEN_OFS = 8'h08;
  localparam logic [7:0] CONTROL_OFS = 8'h0C;
  localparam logic [7:0] COMMON_OFS = 8'h10;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int ST_ACTION_BIT = 0;
  localparam int ST_CLRCHK_BIT = 1;
  localparam int ST_GATECHK_BIT = 2;
  localparam int ST_PAIRCLR_BIT = 3;
  localparam int ST_PAIRGATE_BIT = 4;
  localparam int ST_NUMDONE_BIT = 5;
  localparam int ST_PAIRDONE_BIT = 6;
  localparam int ST_TFAULT_BIT = 7;
  localparam int CLK_MHZ = 200;
  localparam int LOAD_LEAD_US = 9;
  localparam int LOAD_LEAD_CYCLES = LOAD_LEAD_US * CLK_MHZ;
  localparam int LEAD_CNT_W = 11;
  typedef enum logic [2:0] {PH_IDLE, PH_SENSE, PH_DELAY, PH_UP, PH_DASH} phase_t;
endpackage

// [hw/pin_sync.sv]
// three-stage pin synchroniser; output follows once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic mclk,
  input wire logic rstSync_n,
  input wire logic pin,
  output logic level
);
  logic s1, s2, s3;
  logic next_level;
  always_comb begin
    next_level = (s2 == s3) ? s3 : level;
  end
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
    end
  end
endmodule
`default_nettype wire

// [hw/half_adder_chain.sv]
// ripple half-adder chain: value plus a constant one, carry out dropped
`timescale 1ns/1ps
`default_nettype none
module half_adder_chain #(
  parameter int W = 10
) (
  input wire logic [W-1:0] value,
  output logic [W-1:0] sum
);
  logic [W:0] carry;
  assign carry[0] = 1'b1;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_stage
      assign sum[i] = value[i] ^ carry[i];
      assign carry[i+1] = value[i] & carry[i];
    end
  endgenerate
endmodule
`default_nettype wire

// [hw/mem_xfer_seq.sv]
// memory-paced clear/gate sequencer and shared regeneration/control counter
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module mem_xfer_seq #(
  parameter int ADDR_W = xfer_seq_pkg::ADDR_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // memory pulse train pins
  input wire logic actionSensePin,
  input wire logic delayPin,
  input wire logic upCounterPin,
  input wire logic writingDashPin,
  input wire logic dashEndPin,
  // decoding and control, same clock
  input wire logic control_operate_flag,
  input wire logic trueUseMem,
  input wire logic falseUseMem,
  input wire logic orderPairFetch,
  input wire logic arithOrder,
  input wire logic aOrder,
  input wire logic [ADDR_W-1:0] orderAddr,
  // strobes to registers
  output logic number_reg_clear_strobe,
  output logic memToNumberGate,
  output logic arithToNumberGate,
  output logic orderRegClear,
  output logic orderRegGate,
  // status to control and memory
  output logic action_regen_flag,
  output logic numberXferDone,
  output logic orderPairDone,
  output logic [ADDR_W-1:0] memAddr
);
  logic rstA, rstSync_n;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstA <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstA <= 1'b1;
      rstSync_n <= rstA;
    end
  end

  // pulse train synchronisers and edge detection
  logic [4:0] pinIn, lvl, lvlPrev, edg;
  assign pinIn = {dashEndPin, writingDashPin, upCounterPin, delayPin, actionSensePin};
  genvar k;
  generate
    for (k = 0; k < 5; k++) begin : g_sync
      pin_sync u_sync (
        .mclk(mclk),
        .rstSync_n(rstSync_n),
        .pin(pinIn[k]),
        .level(lvl[k])
      );
    end
  endgenerate
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      lvlPrev <= 5'h00;
    end else begin
      lvlPrev <= lvl;
    end
  end
  assign edg = lvl & ~lvlPrev;
  logic senseE, delayE, upE, wdE, deE, upLvl, wdLvl;
  assign senseE = edg[0];
  assign delayE = edg[1];
  assign upE = edg[2];
  assign wdE = edg[3];
  assign deE = edg[4];
  assign upLvl = lvl[2];
  assign wdLvl = lvl[3];

  // register state
  logic [31:0] ctrlReg, next_ctrlReg;
  logic timingFault, next_timingFault;
  logic enable;
  assign enable = ctrlReg[xfer_seq_pkg::CTRL_ENABLE_BIT];

  // sequencer state
  xfer_seq_pkg::phase_t phase, next_phase;
  logic isTrue, isFalse, isPair;
  logic next_isTrue, next_isFalse, next_isPair, next_actionFlag;
  logic next_numClr, next_memGate, next_arithGate, next_pairClr, next_pairGate;
  logic clearCheck, gateCheck, pairClearCheck, pairGateCheck;
  logic next_clearCheck, next_gateCheck, next_pairClearCheck, next_pairGateCheck;
  logic next_numDone, next_pairDone;
  logic action, memEnable, upOk, wdOk, upAcc, wdAcc, deAcc;
  assign action = !action_regen_flag;
  assign memEnable = trueUseMem || falseUseMem || orderPairFetch;
  // pulses out of order are ignored so a glitch cannot gate a register
  assign upOk = upLvl && (phase == xfer_seq_pkg::PH_DELAY || phase == xfer_seq_pkg::PH_UP);
  assign wdOk = wdLvl && (phase == xfer_seq_pkg::PH_UP || phase == xfer_seq_pkg::PH_DASH);
  assign upAcc = upE && phase == xfer_seq_pkg::PH_DELAY;
  assign wdAcc = wdE && phase == xfer_seq_pkg::PH_UP;
  assign deAcc = deE && phase == xfer_seq_pkg::PH_DASH;

  always_comb begin
    next_phase = phase;
    next_actionFlag = action_regen_flag;
    next_isTrue = isTrue;
    next_isFalse = isFalse;
    next_isPair = isPair;
    if (senseE) begin
      next_phase = xfer_seq_pkg::PH_SENSE;
      if (action) begin
        next_actionFlag = 1'b1;
        next_isTrue = 1'b0;
        next_isFalse = 1'b0;
        next_isPair = 1'b0;
      end else if (enable && memEnable) begin
        next_actionFlag = 1'b0;
        next_isTrue = trueUseMem;
        next_isFalse = falseUseMem;
        next_isPair = orderPairFetch;
      end
    end else if (delayE && phase == xfer_seq_pkg::PH_SENSE) begin
      next_phase = xfer_seq_pkg::PH_DELAY;
    end else if (upAcc) begin
      next_phase = xfer_seq_pkg::PH_UP;
    end else if (wdAcc) begin
      next_phase = xfer_seq_pkg::PH_DASH;
    end else if (deAcc) begin
      next_phase = xfer_seq_pkg::PH_IDLE;
    end
    next_numClr = action && (arithOrder || aOrder) && upOk;
    next_memGate = action && arithOrder && wdOk;
    next_arithGate = action && aOrder && wdOk;
    next_pairClr = action && isPair && upOk;
    next_pairGate = action && isPair && wdOk;
    next_clearCheck = clearCheck;
    next_gateCheck = gateCheck;
    next_pairClearCheck = pairClearCheck;
    next_pairGateCheck = pairGateCheck;
    // a strobe beats the preset so a confirmation is never lost
    if (number_reg_clear_strobe) begin
      next_clearCheck = 1'b0;
    end else if (control_operate_flag) begin
      next_clearCheck = 1'b1;
    end
    if (memToNumberGate || arithToNumberGate) begin
      next_gateCheck = 1'b0;
    end else if (control_operate_flag) begin
      next_gateCheck = 1'b1;
    end
    if (orderRegClear) begin
      next_pairClearCheck = 1'b0;
    end else if (!control_operate_flag) begin
      next_pairClearCheck = 1'b1;
    end
    if (orderRegGate) begin
      next_pairGateCheck = 1'b0;
    end else if (!control_operate_flag) begin
      next_pairGateCheck = 1'b1;
    end
    next_numDone = !clearCheck && !gateCheck;
    next_pairDone = !pairClearCheck && !pairGateCheck;
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      phase <= xfer_seq_pkg::PH_IDLE;
      action_regen_flag <= 1'b1;
      isTrue <= 1'b0;
      isFalse <= 1'b0;
      isPair <= 1'b0;
      number_reg_clear_strobe <= 1'b0;
      memToNumberGate <= 1'b0;
      arithToNumberGate <= 1'b0;
      orderRegClear <= 1'b0;
      orderRegGate <= 1'b0;
      clearCheck <= 1'b1;
      gateCheck <= 1'b1;
      pairClearCheck <= 1'b1;
      pairGateCheck <= 1'b1;
      numberXferDone <= 1'b0;
      orderPairDone <= 1'b0;
    end else begin
      phase <= next_phase;
      action_regen_flag <= next_actionFlag;
      isTrue <= next_isTrue;
      isFalse <= next_isFalse;
      isPair <= next_isPair;
      number_reg_clear_strobe <= next_numClr;
      memToNumberGate <= next_memGate;
      arithToNumberGate <= next_arithGate;
      orderRegClear <= next_pairClr;
      orderRegGate <= next_pairGate;
      clearCheck <= next_clearCheck;
      gateCheck <= next_gateCheck;
      pairClearCheck <= next_pairClearCheck;
      pairGateCheck <= next_pairGateCheck;
      numberXferDone <= next_numDone;
      orderPairDone <= next_pairDone;
    end
  end

  // shared counter: regeneration, control and common registers
  logic [ADDR_W-1:0] regenReg, controlReg, commonReg, incr;
  logic [ADDR_W-1:0] next_regenReg, next_controlReg, next_commonReg, next_memAddr;
  logic [xfer_seq_pkg::LEAD_CNT_W-1:0] leadCnt, next_leadCnt;
  logic countRegen, countControl, xferControl;
  logic busWrite, ctrlAddrWrite, statusWrite;
  logic [31:0] busWdata;
  half_adder_chain #(.W(ADDR_W)) u_incr (
    .value(commonReg),
    .sum(incr)
  );
  assign countRegen = action_regen_flag || isFalse;
  assign countControl = action && isPair;
  assign xferControl = action && isFalse;

  always_comb begin
    next_regenReg = regenReg;
    next_controlReg = controlReg;
    next_commonReg = commonReg;
    if (senseE) begin
      next_commonReg = '0;
    end else if (upAcc) begin
      next_commonReg = countRegen ? regenReg : controlReg;
    end
    if (wdAcc) begin
      if (countRegen) begin
        next_regenReg = '0;
      end
      if (countControl || xferControl) begin
        next_controlReg = '0;
      end
    end else if (deAcc) begin
      if (countRegen) begin
        next_regenReg = incr;
      end
      if (countControl) begin
        next_controlReg = incr;
      end else if (xferControl) begin
        next_controlReg = orderAddr;
      end
    end else if (ctrlAddrWrite) begin
      next_controlReg = busWdata[ADDR_W-1:0];
    end
    // common register is only touched at sense and up counter, so it holds over the beam
    next_memAddr = (action && isTrue) ? orderAddr : commonReg;
    next_leadCnt = leadCnt;
    if (upAcc) begin
      next_leadCnt = '0;
    end else if (leadCnt != xfer_seq_pkg::LEAD_CNT_W'(xfer_seq_pkg::LOAD_LEAD_CYCLES)) begin
      next_leadCnt = leadCnt + 1'b1;
    end
    next_timingFault = timingFault;
    if (wdAcc && leadCnt < xfer_seq_pkg::LEAD_CNT_W'(xfer_seq_pkg::LOAD_LEAD_CYCLES)) begin
      next_timingFault = 1'b1;
    end else if (statusWrite && busWdata[xfer_seq_pkg::ST_TFAULT_BIT]) begin
      next_timingFault = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      regenReg <= '0;
      controlReg <= '0;
      commonReg <= '0;
      memAddr <= '0;
      leadCnt <= '0;
      timingFault <= 1'b0;
    end else begin
      regenReg <= next_regenReg;
      controlReg <= next_controlReg;
      commonReg <= next_commonReg;
      memAddr <= next_memAddr;
      leadCnt <= next_leadCnt;
      timingFault <= next_timingFault;
    end
  end

  // AHB-Lite slave: zero wait states, reads prepared in the address phase
  logic addrPhase, wrPend, next_wrPend;
  logic [7:0] wrAddr, next_wrAddr;
  logic [31:0] next_hrdata, statusWord;
  assign addrPhase = hsel && htrans[1] && hready;
  assign busWrite = wrPend;
  assign busWdata = hwdata;
  assign ctrlAddrWrite = busWrite && wrAddr == xfer_seq_pkg::CONTROL_OFS;
  assign statusWrite = busWrite && wrAddr == xfer_seq_pkg::STATUS_OFS;
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[xfer_seq_pkg::ST_ACTION_BIT] = action_regen_flag;
    statusWord[xfer_seq_pkg::ST_CLRCHK_BIT] = clearCheck;
    statusWord[xfer_seq_pkg::ST_GATECHK_BIT] = gateCheck;
    statusWord[xfer_seq_pkg::ST_PAIRCLR_BIT] = pairClearCheck;
    statusWord[xfer_seq_pkg::ST_PAIRGATE_BIT] = pairGateCheck;
    statusWord[xfer_seq_pkg::ST_NUMDONE_BIT] = numberXferDone;
    statusWord[xfer_seq_pkg::ST_PAIRDONE_BIT] = orderPairDone;
    statusWord[xfer_seq_pkg::ST_TFAULT_BIT] = timingFault;
  end
  always_comb begin
    next_wrPend = addrPhase && hwrite;
    next_wrAddr = addrPhase ? haddr[7:0] : wrAddr;
    next_hrdata = 32'h0000_0000;
    if (addrPhase && !hwrite && haddr[31:8] == 24'h00_0000) begin
      if (haddr[7:0] == xfer_seq_pkg::CTRL_OFS) begin
        next_hrdata = ctrlReg;
      end else if (haddr[7:0] == xfer_seq_pkg::STATUS_OFS) begin
        next_hrdata = statusWord;
      end else if (haddr[7:0] == xfer_seq_pkg::REGEN_OFS) begin
        next_hrdata = {{(32-ADDR_W){1'b0}}, regenReg};
      end else if (haddr[7:0] == xfer_seq_pkg::CONTROL_OFS) begin
        next_hrdata = {{(32-ADDR_W){1'b0}}, controlReg};
      end else if (haddr[7:0] == xfer_seq_pkg::COMMON_OFS) begin
        next_hrdata = {{(32-ADDR_W){1'b0}}, commonReg};
      end
    end
    next_ctrlReg = ctrlReg;
    if (busWrite && wrAddr == xfer_seq_pkg::CTRL_OFS) begin
      next_ctrlReg = {31'h0000_0000, busWdata[xfer_seq_pkg::CTRL_ENABLE_BIT]};
    end
  end
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ctrlReg <= xfer_seq_pkg::CTRL_RESET;
    end else begin
      wrPend <= next_wrPend;
      wrAddr <= next_wrAddr;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ctrlReg <= next_ctrlReg;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstSync_n);
  AST_CLEAR_TIMING: assert property (
    number_reg_clear_strobe |-> $past(upOk && action && (arithOrder || aOrder)))
    else $error("number clear outside up counter action window");
  AST_GATE_TIMING: assert property (
    (memToNumberGate || arithToNumberGate) |-> $past(wdOk && action))
    else $error("number gate outside writing dash action window");
  AST_CLEAR_CHECK: assert property (
    number_reg_clear_strobe |=> !clearCheck)
    else $error("clear check flag not driven to zero");
  AST_GATE_CHECK: assert property (
    memToNumberGate |=> !gateCheck)
    else $error("gate check flag not driven to zero");
  AST_DONE: assert property (
    numberXferDone |-> $past(!clearCheck && !gateCheck))
    else $error("done without both check flags cleared");
  AST_PRESET: assert property (
    (control_operate_flag && !number_reg_clear_strobe) |=> clearCheck)
    else $error("clear check flag not preset in control state");
  AST_PAIR_PRESET: assert property (
    (!control_operate_flag && !orderRegGate) |=> pairGateCheck)
    else $error("pair gate check flag not preset in operate state");
  AST_COMMON_CLEAR: assert property (
    senseE |=> commonReg == '0)
    else $error("common register not cleared at action sense");
  AST_REGEN_INC: assert property (
    (deAcc && countRegen) |=> regenReg == ADDR_W'($past(commonReg) + 1'b1))
    else $error("regeneration register not loaded with common plus one");
  AST_RETURN_REGEN: assert property (
    (senseE && action) |=> action_regen_flag ##1 !number_reg_clear_strobe)
    else $error("action sense did not return to regenerate");
  AST_ADDR_SELECT: assert property (
    $past(action && isTrue) |-> memAddr == $past(orderAddr))
    else $error("address generator not fed order address in true use cycle");
endmodule
`default_nettype wire

// [testbench/pulse_train.sv]
// behavioural memory pulse train: action sense, delay, up counter, writing dash, dash end
`timescale 1ns/1ps
`default_nettype none
module pulse_train #(
  parameter int WIDTH = 4,
  parameter int DASH_W = 6
) (
  // clock
  input wire logic mclk,
  // frame request
  input wire logic start,
  input wire logic [11:0] gap,
  output logic busy,
  // pulse levels, bit 0 sense up to bit 4 dash end
  output logic [4:0] pins
);
  initial begin
    busy = 1'b0;
    pins = 5'h00;
  end

  // low spacing after each pulse keeps every level long enough for the synchroniser
  task automatic pulse(input int i, input int n);
    pins[i] <= 1'b1;
    repeat (n) @(posedge mclk);
    pins[i] <= 1'b0;
    repeat (WIDTH) @(posedge mclk);
  endtask

  // pins stay low between frames, as the memory does
  always begin
    @(posedge mclk);
    if (start) begin
      busy <= 1'b1;
      pulse(0, WIDTH);
      pulse(1, WIDTH);
      pulse(2, WIDTH);
      repeat (gap) @(posedge mclk);
      pulse(3, DASH_W);
      pulse(4, WIDTH);
      busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the memory-paced sequencer and shared counter
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int UPW = 4;
  localparam int DW = 6;
  logic mclk, rst_n, hsel, hwrite, start, busy, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0] htrans;
  logic [11:0] gap;
  logic [4:0] pins;
  logic control_operate_flag, trueUseMem, falseUseMem, orderPairFetch, arithOrder, aOrder;
  logic number_reg_clear_strobe, memToNumberGate, arithToNumberGate, orderRegClear;
  logic orderRegGate, action_regen_flag, numberXferDone, orderPairDone;
  logic [9:0] orderAddr, memAddr, addrSeen;
  int n_mismatch = 0;
  int n_tests = 0;
  int nClr, nGate, nArith, nOClr, nOGate;

  mem_xfer_seq dut (
    .mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .actionSensePin(pins[0]), .delayPin(pins[1]), .upCounterPin(pins[2]),
    .writingDashPin(pins[3]), .dashEndPin(pins[4]),
    .control_operate_flag, .trueUseMem, .falseUseMem, .orderPairFetch, .arithOrder,
    .aOrder, .orderAddr, .number_reg_clear_strobe, .memToNumberGate, .arithToNumberGate,
    .orderRegClear, .orderRegGate, .action_regen_flag, .numberXferDone, .orderPairDone,
    .memAddr
  );

  pulse_train #(.WIDTH(UPW), .DASH_W(DW)) mem (.mclk, .start, .gap, .busy, .pins);

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // strobe lengths per memory frame, zeroed as a frame is requested
  always @(posedge mclk) begin
    nClr <= start ? 0 : nClr + int'(number_reg_clear_strobe === 1'b1);
    nGate <= start ? 0 : nGate + int'(memToNumberGate === 1'b1);
    nArith <= start ? 0 : nArith + int'(arithToNumberGate === 1'b1);
    nOClr <= start ? 0 : nOClr + int'(orderRegClear === 1'b1);
    nOGate <= start ? 0 : nOGate + int'(orderRegGate === 1'b1);
    if (memToNumberGate === 1'b1) begin
      addrSeen <= memAddr;
    end
  end

  task automatic conclude();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // sel 0 waits for hready, sel 1 for the end of a memory frame
  task automatic waitOn(input bit sel, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while ((sel ? busy !== 1'b0 : hreadyout !== 1'b1) && n < lim);
    // judge by the awaited condition, so an answer on the last allowed edge still counts
    if (sel ? busy !== 1'b0 : hreadyout !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
  endtask

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    waitOn(1'b0, 100);
    htrans <= 2'h0;
    hwdata <= wd;
    waitOn(1'b0, 100);
    rdv = hrdata;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h00000000);
    chk(rdv, exp);
  endtask

  // the extra cycles cover the pin synchroniser and the counter update
  task automatic memCycle(input logic [11:0] g);
    gap <= g;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    waitOn(1'b1, 4000);
    repeat (10) @(posedge mclk);
  endtask

  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h00000000;
    start = 1'b0;
    gap = 12'h000;
    control_operate_flag = 1'b1;
    {trueUseMem, falseUseMem, orderPairFetch, arithOrder, aOrder} = 5'h00;
    orderAddr = 10'h2A5;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rdChk(xfer_seq_pkg::CTRL_OFS, 32'h00000001);
    chk({31'h00000000, hresp}, 32'h00000000);
    rdChk(xfer_seq_pkg::STATUS_OFS, 32'h0000001F);
    rdChk(xfer_seq_pkg::CONTROL_OFS, 32'h00000000);
    rdChk(8'h14, 32'h00000000);
    memCycle(12'd2400);
    rdChk(xfer_seq_pkg::REGEN_OFS, 32'h00000001);
    xfer(xfer_seq_pkg::REGEN_OFS, 1'b1, 32'h000003FF);
    rdChk(xfer_seq_pkg::REGEN_OFS, 32'h00000001);
    // arithmetic word from memory in operate state
    control_operate_flag <= 1'b0;
    trueUseMem <= 1'b1;
    arithOrder <= 1'b1;
    memCycle(12'd2400);
    trueUseMem <= 1'b0;
    arithOrder <= 1'b0;
    chk(nClr, UPW);
    chk(nGate, DW);
    chk({31'h00000000, action_regen_flag}, 32'h00000000);
    chk({31'h00000000, numberXferDone}, 32'h00000001);
    chk({22'h000000, addrSeen}, 32'h000002A5);
    rdChk(xfer_seq_pkg::STATUS_OFS, 32'h00000038);
    rdChk(xfer_seq_pkg::REGEN_OFS, 32'h00000001);
    memCycle(12'd2400);
    rdChk(xfer_seq_pkg::STATUS_OFS, 32'h00000039);
    rdChk(xfer_seq_pkg::COMMON_OFS, 32'h00000001);
    chk({22'h000000, memAddr}, 32'h00000001);
    rdChk(xfer_seq_pkg::REGEN_OFS, 32'h00000002);
    control_operate_flag <= 1'b1;
    repeat (3) @(posedge mclk);
    rdChk(xfer_seq_pkg::STATUS_OFS, 32'h0000001F);
    // order pair fetch from the top address wraps the control count
    xfer(xfer_seq_pkg::CONTROL_OFS, 1'b1, 32'h000003FF);
    orderPairFetch <= 1'b1;
    memCycle(12'd2400);
    orderPairFetch <= 1'b0;
    chk(nOClr, UPW);
    chk(nOGate, DW);
    chk({31'h00000000, orderPairDone}, 32'h00000001);
    chk(nClr, 0);
    rdChk(xfer_seq_pkg::CONTROL_OFS, 32'h00000000);
    rdChk(xfer_seq_pkg::STATUS_OFS, 32'h00000046);
    rdChk(xfer_seq_pkg::REGEN_OFS, 32'h00000002);
    memCycle(12'd2400);
    // false use with an A order: copy and transfer of control
    falseUseMem <= 1'b1;
    aOrder <= 1'b1;
    orderAddr <= 10'h155;
    memCycle(12'd2400);
    falseUseMem <= 1'b0;
    aOrder <= 1'b0;
    chk(nArith, DW);
    chk(nClr, UPW);
    chk(nGate, 0);
    rdChk(xfer_seq_pkg::CONTROL_OFS, 32'h00000155);
    rdChk(xfer_seq_pkg::REGEN_OFS, 32'h00000004);
    memCycle(12'd2400);
    // disabled: no action cycle may start
    xfer(xfer_seq_pkg::CTRL_OFS, 1'b1, 32'h00000000);
    trueUseMem <= 1'b1;
    arithOrder <= 1'b1;
    memCycle(12'd2400);
    trueUseMem <= 1'b0;
    arithOrder <= 1'b0;
    chk(nClr, 0);
    rdChk(xfer_seq_pkg::STATUS_OFS, 32'h00000047);
    rdChk(xfer_seq_pkg::REGEN_OFS, 32'h00000006);
    xfer(xfer_seq_pkg::CTRL_OFS, 1'b1, 32'h00000001);
    // writing dash too soon after the address load
    memCycle(12'd100);
    xfer(xfer_seq_pkg::STATUS_OFS, 1'b0, 32'h00000000);
    chk({31'h00000000, rdv[7]}, 32'h00000001);
    xfer(xfer_seq_pkg::STATUS_OFS, 1'b1, 32'h00000080);
    xfer(xfer_seq_pkg::STATUS_OFS, 1'b0, 32'h00000000);
    chk({31'h00000000, rdv[7]}, 32'h00000000);
    // operate state presets the order-pair check flags again
    control_operate_flag <= 1'b0;
    repeat (3) @(posedge mclk);
    rdChk(xfer_seq_pkg::STATUS_OFS, 32'h0000001F);
    chk({31'h00000000, orderPairDone}, 32'h00000000);
    conclude();
  end
endmodule
`default_nettype wire
